// file: ppr_cfg.svh
// Constants of the process regulator: register offsets, fields, resets and timing.
// Assumes a 50 MHz core clock; included by the register file, the regulator core and the bench.
// Summary of operation
// - Mode 0 off; 1 D on deviation; 2 D on feedback; 3/4 add to reference.
// - Integral accumulator clears to zero whenever the drive stops.
// - Integral accumulator is clamped to a percentage of maximum frequency.
// - Closed cancel contact while running passes the setpoint straight through.
// - Deviation is multiplied by a proportional gain of 0.00 to 25.00.
// - Deviation accumulates at a rate set by integral time 0 to 360 s.
// - Derivative term scales with derivative time 0 to 10 s.
// - Combined result is clamped to plus and minus a limit of 0 to 100 percent, default 100.
// - A signed bias of -100 to +100 percent is added.
// - Result passes a first-order lag of 0 to 100 s; zero means none.
// - Output sense 0 is normal acting, 1 inverse acting.
// - Final output scales by gain 0.0 to 25.0 and is readable.
// - Negative output clamps to zero, or reverses the motor when selected.
// - Reverse prohibit blocks any reversal of the motor.
// - Setpoint from analog voltage when source is 1, step references when 0.
// - Feedback on second analog input: 4-20 mA when selection is 2, else voltage.
`ifndef PPR_CFG_SVH
`define PPR_CFG_SVH
`define PPR_CLK_MHZ 50
`define PPR_CTRL_PERIOD_US 1000
`define PPR_TICKS_PER_CS 10
`define PPR_Q_ONE 32'sd16384
`define PPR_PCT_FULL 32'sd1000
`define PPR_MA4_CODE 32'sd3277
`define PPR_FRAC 8
`define PPR_FN_PID_FB 5'h0b
`define PPR_FN_CANCEL 7'h13
`define PPR_OFF_MODE 8'h00
`define PPR_OFF_MON 8'h30
`define PPR_OFF_STAT 8'h34
`define PPR_MISC_REF 0
`define PPR_MISC_REVP 1
`define PPR_MISC_SIG2 2
`define PPR_MISC_AN1 8
`define PPR_MISC_CONT 16
`define PPR_RST_KP 32'h0000_0064
`define PPR_RST_TI 32'h0000_0064
`define PPR_RST_LIM 32'h0000_03e8
`define PPR_RST_FGAIN 32'h0000_000a
`endif

// file: ppr_pkg.sv
// Types shared by the regulator modules.
// Assumes ppr_cfg.svh is on the include path.
package ppr_pkg;
  typedef enum logic [2:0] {
    PPR_OFF = 3'b000,
    PPR_PID_DEV = 3'b001,
    PPR_PID_FF = 3'b010,
    PPR_ADD_FB = 3'b011,
    PPR_ADD_FF = 3'b100
  } ppr_mode_e;
  typedef struct packed {
    ppr_mode_e mode;
    logic [11:0] kp;
    logic [15:0] ti;
    logic [9:0] ilim;
    logic [9:0] td;
    logic [9:0] olim;
    logic signed [10:0] bias;
    logic [13:0] lag;
    logic sense;
    logic [7:0] fgain;
    logic negh;
    logic ref_src;
    logic rev_prohibit;
    logic [1:0] sig2_sel;
    logic [4:0] an1_fn;
    logic [6:0] contact_fn;
  } ppr_cfg_s;
endpackage

// file: ppr_cfg_if.sv
// Carries settings from the register file to the regulator core and state back.
// Assumes both ends run on the same core clock.
`timescale 1ns/1ps
`default_nettype none
interface ppr_cfg_if import ppr_pkg::*; ();
  ppr_cfg_s cfg;
  logic signed [15:0] monitor;
  logic [2:0] status;
  modport regs (output cfg, input monitor, input status);
  modport core (input cfg, output monitor, output status);
endinterface
`default_nettype wire

// file: ppr_axil.sv
// AXI4-Lite register file of the regulator.
// Assumes one write and one read under way at a time; answers SLVERR off the map.
`timescale 1ns/1ps
`default_nettype none
`include "ppr_cfg.svh"
module ppr_axil import ppr_pkg::*; (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // AXI4-Lite slave.
  input wire logic [7:0] awaddr_i,
  input wire logic awvalid_i,
  output logic awready_o,
  input wire logic [31:0] wdata_i,
  input wire logic [3:0] wstrb_i,
  input wire logic wvalid_i,
  output logic wready_o,
  output logic [1:0] bresp_o,
  output logic bvalid_o,
  input wire logic bready_i,
  input wire logic [7:0] araddr_i,
  input wire logic arvalid_i,
  output logic arready_o,
  output logic [31:0] rdata_o,
  output logic [1:0] rresp_o,
  output logic rvalid_o,
  input wire logic rready_i,
  // Settings and state.
  ppr_cfg_if.regs bus
);
  typedef struct packed {
    logic awrdy, wrdy, arrdy, aw_ok, w_ok, bvalid, rvalid;
    logic [1:0] bresp, rresp;
    logic [7:0] awaddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [11:0][31:0] regs;
  } ppr_axs_s;
  ppr_axs_s st, nx;

  function automatic logic [31:0] reg_mask(input logic [3:0] i);
    case (i)
      4'h0: reg_mask = 32'h0000_0007;
      4'h1: reg_mask = 32'h0000_0fff;
      4'h2: reg_mask = 32'h0000_ffff;
      4'h6: reg_mask = 32'h0000_07ff;
      4'h7: reg_mask = 32'h0000_3fff;
      4'h8, 4'ha: reg_mask = 32'h0000_0001;
      4'h9: reg_mask = 32'h0000_00ff;
      4'hb: reg_mask = 32'h007f_1f0f;
      default: reg_mask = 32'h0000_03ff;
    endcase
  endfunction

  always_comb begin
    nx = st;
    if (st.awrdy && awvalid_i) begin
      nx.awrdy = 1'b0;
      nx.aw_ok = 1'b1;
      nx.awaddr = awaddr_i;
    end
    if (st.wrdy && wvalid_i) begin
      nx.wrdy = 1'b0;
      nx.w_ok = 1'b1;
      nx.wdata = wdata_i;
      nx.wstrb = wstrb_i;
    end
    if (st.aw_ok && st.w_ok) begin
      nx.aw_ok = 1'b0;
      nx.w_ok = 1'b0;
      nx.bvalid = 1'b1;
      nx.bresp = 2'h2;
      if (st.awaddr < `PPR_OFF_MON) begin
        nx.bresp = 2'h0;
        for (int b = 0; b < 4; b++) begin
          if (st.wstrb[b]) begin
            nx.regs[st.awaddr[5:2]][8*b +: 8] = st.wdata[8*b +: 8];
          end
        end
        nx.regs[st.awaddr[5:2]] = nx.regs[st.awaddr[5:2]] & reg_mask(st.awaddr[5:2]);
      end
    end
    if (st.bvalid && bready_i) begin
      nx.bvalid = 1'b0;
      nx.awrdy = 1'b1;
      nx.wrdy = 1'b1;
    end
    if (st.arrdy && arvalid_i) begin
      nx.arrdy = 1'b0;
      nx.rvalid = 1'b1;
      nx.rresp = 2'h0;
      if (araddr_i < `PPR_OFF_MON) begin
        nx.rdata = st.regs[araddr_i[5:2]];
      end else if (araddr_i[7:2] == `PPR_OFF_MON >> 2) begin
        nx.rdata = {{16{bus.monitor[15]}}, bus.monitor};
      end else if (araddr_i[7:2] == `PPR_OFF_STAT >> 2) begin
        nx.rdata = {29'h0, bus.status};
      end else begin
        nx.rdata = 32'h0;
        nx.rresp = 2'h2;
      end
    end
    if (st.rvalid && rready_i) begin
      nx.rvalid = 1'b0;
      nx.arrdy = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '0;
      st.awrdy <= 1'b1;
      st.wrdy <= 1'b1;
      st.arrdy <= 1'b1;
      st.regs[1] <= `PPR_RST_KP;
      st.regs[2] <= `PPR_RST_TI;
      st.regs[3] <= `PPR_RST_LIM;
      st.regs[5] <= `PPR_RST_LIM;
      st.regs[9] <= `PPR_RST_FGAIN;
    end else begin
      st <= nx;
    end
  end

  assign awready_o = st.awrdy;
  assign wready_o = st.wrdy;
  assign bvalid_o = st.bvalid;
  assign bresp_o = st.bresp;
  assign arready_o = st.arrdy;
  assign rvalid_o = st.rvalid;
  assign rdata_o = st.rdata;
  assign rresp_o = st.rresp;
  assign bus.cfg.mode = ppr_mode_e'(st.regs[0][2:0]);
  assign bus.cfg.kp = st.regs[1][11:0];
  assign bus.cfg.ti = st.regs[2][15:0];
  assign bus.cfg.ilim = st.regs[3][9:0];
  assign bus.cfg.td = st.regs[4][9:0];
  assign bus.cfg.olim = st.regs[5][9:0];
  assign bus.cfg.bias = st.regs[6][10:0];
  assign bus.cfg.lag = st.regs[7][13:0];
  assign bus.cfg.sense = st.regs[8][0];
  assign bus.cfg.fgain = st.regs[9][7:0];
  assign bus.cfg.negh = st.regs[10][0];
  assign bus.cfg.ref_src = st.regs[11][`PPR_MISC_REF];
  assign bus.cfg.rev_prohibit = st.regs[11][`PPR_MISC_REVP];
  assign bus.cfg.sig2_sel = st.regs[11][`PPR_MISC_SIG2 +: 2];
  assign bus.cfg.an1_fn = st.regs[11][`PPR_MISC_AN1 +: 5];
  assign bus.cfg.contact_fn = st.regs[11][`PPR_MISC_CONT +: 7];
endmodule // ppr_axil
`default_nettype wire

// file: ppr_top.sv
// Process regulator core: setpoint and feedback in, frequency reference out.
// Assumes analog codes come from converter logic on the core clock, 16384 = full
// scale, and that the cancel contact is a raw pin.
//
// The register addresses and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "ppr_cfg.svh"
module ppr_top import ppr_pkg::*; #(
  parameter int CTRL_CYCLES = `PPR_CTRL_PERIOD_US * `PPR_CLK_MHZ
) (
  // Clock and reset.
  input wire logic core_clk_i,
  input wire logic rst_i,
  // AXI4-Lite slave.
  input wire logic [7:0] awaddr_i,
  input wire logic awvalid_i,
  output logic awready_o,
  input wire logic [31:0] wdata_i,
  input wire logic [3:0] wstrb_i,
  input wire logic wvalid_i,
  output logic wready_o,
  output logic [1:0] bresp_o,
  output logic bvalid_o,
  input wire logic bready_i,
  input wire logic [7:0] araddr_i,
  input wire logic arvalid_i,
  output logic arready_o,
  output logic [31:0] rdata_o,
  output logic [1:0] rresp_o,
  output logic rvalid_o,
  input wire logic rready_i,
  // Drive sequence and contacts.
  input wire logic run_i,
  input wire logic cancel_contact_i,
  // Setpoint and feedback sources.
  input wire logic signed [15:0] analog1_i,
  input wire logic signed [15:0] analog2_i,
  input wire logic signed [15:0] step_ref_i,
  // Frequency reference.
  output logic signed [15:0] freq_ref_o,
  output logic reverse_o,
  output logic active_o
);
  typedef struct packed {
    logic cancel_s1;
    logic cancel_s2;
    logic [15:0] tick_cnt;
    logic tick;
    logic signed [31:0] integ;
    logic signed [31:0] prev_d;
    logic signed [31:0] lag;
    logic signed [15:0] freq;
    logic signed [15:0] mon;
    logic rev;
    logic active;
    logic canceled;
  } ppr_core_s;

  ppr_cfg_if cfg_if ();
  ppr_cfg_s cfg;
  ppr_core_s st, nx;

  ppr_axil u_regs (
    .clk_i(core_clk_i),
    .rst_i(rst_i),
    .awaddr_i(awaddr_i),
    .awvalid_i(awvalid_i),
    .awready_o(awready_o),
    .wdata_i(wdata_i),
    .wstrb_i(wstrb_i),
    .wvalid_i(wvalid_i),
    .wready_o(wready_o),
    .bresp_o(bresp_o),
    .bvalid_o(bvalid_o),
    .bready_i(bready_i),
    .araddr_i(araddr_i),
    .arvalid_i(arvalid_i),
    .arready_o(arready_o),
    .rdata_o(rdata_o),
    .rresp_o(rresp_o),
    .rvalid_o(rvalid_o),
    .rready_i(rready_i),
    .bus(cfg_if.regs)
  );

  assign cfg = cfg_if.cfg;
  assign cfg_if.monitor = st.mon;
  assign cfg_if.status = {st.canceled, st.rev, st.active};

  function automatic logic signed [31:0] clamp_sym(input logic signed [31:0] x,
                                                   input logic signed [31:0] lim);
    if (x > lim) begin
      clamp_sym = lim;
    end else if (x < -lim) begin
      clamp_sym = -lim;
    end else begin
      clamp_sym = x;
    end
  endfunction

  // Converts a setting in 0.1 % steps to the internal full-scale units.
  function automatic logic signed [31:0] pct_q(input logic signed [11:0] p);
    pct_q = (32'(p) * `PPR_Q_ONE) / `PPR_PCT_FULL;
  endfunction

  function automatic logic signed [15:0] sat16(input logic signed [31:0] x);
    logic signed [31:0] c;
    c = clamp_sym(x, 32'sd32767);
    sat16 = c[15:0];
  endfunction

  logic signed [31:0] sp_w, an2_w, fb_w, dev_w, p_w;
  logic signed [31:0] iinc_w, integ_w, ilim_w;
  logic signed [31:0] dsrc_w, d_w, sum_w, olim_w, x_w, lag_w, out_w, res_w;
  logic signed [15:0] mon_w, freq_w;
  logic en_w, canc_w, rev_w;

  // Setpoint selection.
  assign sp_w = cfg.ref_src ? 32'(analog1_i) : 32'(step_ref_i);

  // Feedback: live-zero current loop or plain voltage.
  assign an2_w = 32'(analog2_i);
  always_comb begin
    fb_w = an2_w;
    if (cfg.sig2_sel == 2'h2) begin
      fb_w = ((an2_w - `PPR_MA4_CODE) * 32'sd5) / 32'sd4;
      if (fb_w < 32'sd0) begin
        fb_w = 32'sd0;
      end
    end else if (cfg.sig2_sel == 2'h0 && an2_w < 32'sd0) begin
      fb_w = 32'sd0;
    end
  end

  // Deviation with output sense.
  assign dev_w = cfg.sense ? sp_w - fb_w : fb_w - sp_w;

  // Proportional term in hundredths of gain.
  assign p_w = (dev_w * signed'(32'(cfg.kp))) / 32'sd100;

  // Integral: accumulator carries extra fraction bits so slow rates still move.
  assign ilim_w = pct_q(signed'({2'b00, cfg.ilim})) <<< `PPR_FRAC;
  assign iinc_w = (cfg.ti == 16'h0000) ? 32'sd0 :
                  (dev_w <<< `PPR_FRAC) / (signed'(32'(cfg.ti)) * `PPR_TICKS_PER_CS);
  assign integ_w = clamp_sym(st.integ + iinc_w, ilim_w);

  // Derivative on deviation or on oriented feedback, per mode.
  assign dsrc_w = (cfg.mode == PPR_PID_DEV) ? dev_w :
                  (cfg.sense ? -fb_w : fb_w);
  assign d_w = (dsrc_w - st.prev_d) * signed'(32'(cfg.td)) * `PPR_TICKS_PER_CS;

  // Sum, limit and bias.
  assign olim_w = pct_q(signed'({2'b00, cfg.olim}));
  assign sum_w = clamp_sym(p_w + (integ_w >>> `PPR_FRAC) + clamp_sym(d_w, `PPR_Q_ONE),
                           olim_w);
  assign x_w = sum_w + pct_q(signed'({cfg.bias[10], cfg.bias}));

  // First-order lag; a zero time constant passes the value straight on.
  always_comb begin
    if (cfg.lag == 14'h0000) begin
      lag_w = x_w <<< `PPR_FRAC;
    end else begin
      lag_w = st.lag + ((x_w <<< `PPR_FRAC) - st.lag) /
              (signed'(32'(cfg.lag)) * `PPR_TICKS_PER_CS);
    end
  end

  // Final gain in tenths, seen on the monitor register.
  assign out_w = ((lag_w >>> `PPR_FRAC) * signed'(32'(cfg.fgain))) / 32'sd10;
  assign mon_w = sat16(out_w);

  assign en_w = (cfg.mode != PPR_OFF) && (cfg.mode <= PPR_ADD_FF) &&
                (cfg.an1_fn == `PPR_FN_PID_FB);
  assign canc_w = (cfg.contact_fn == `PPR_FN_CANCEL) && st.cancel_s2;

  // Result selection and handling of a negative result.
  always_comb begin
    if (!en_w || canc_w) begin
      res_w = sp_w;
    end else if (cfg.mode == PPR_ADD_FB || cfg.mode == PPR_ADD_FF) begin
      res_w = sp_w + 32'(mon_w);
    end else begin
      res_w = 32'(mon_w);
    end
    rev_w = 1'b0;
    freq_w = sat16(res_w);
    if (res_w < 32'sd0) begin
      if (cfg.negh && !cfg.rev_prohibit) begin
        rev_w = 1'b1;
        freq_w = sat16(-res_w);
      end else begin
        freq_w = 16'sh0000;
      end
    end
  end

  always_comb begin
    nx = st;
    nx.cancel_s1 = cancel_contact_i;
    nx.cancel_s2 = st.cancel_s1;
    nx.tick = 1'b0;
    if (st.tick_cnt == 16'(CTRL_CYCLES - 1)) begin
      nx.tick_cnt = 16'h0000;
      nx.tick = 1'b1;
    end else begin
      nx.tick_cnt = st.tick_cnt + 16'h0001;
    end
    if (!run_i) begin
      nx.integ = 32'sd0;
      nx.lag = 32'sd0;
      nx.prev_d = dsrc_w;
      nx.freq = 16'sh0000;
      nx.rev = 1'b0;
      nx.active = 1'b0;
      nx.canceled = 1'b0;
    end else if (st.tick) begin
      nx.integ = (en_w && !canc_w) ? integ_w : (en_w ? st.integ : 32'sd0);
      nx.prev_d = dsrc_w;
      nx.lag = (en_w && !canc_w) ? lag_w : 32'sd0;
      nx.mon = mon_w;
      nx.freq = freq_w;
      nx.rev = rev_w;
      nx.active = en_w && !canc_w;
      nx.canceled = canc_w;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= nx;
    end
  end

  assign freq_ref_o = st.freq;
  assign reverse_o = st.rev;
  assign active_o = st.active;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  a_integ_stop: assert property (!run_i |=> st.integ == 32'sd0)
    else $error("integral not cleared on stop");
  a_integ_bound: assert property (st.tick && run_i && en_w && !canc_w
    |=> st.integ <= $past(ilim_w) && st.integ >= -$past(ilim_w))
    else $error("integral outside its clamp");
  a_cancel_pass: assert property (st.tick && run_i && canc_w && sp_w >= 0
    && sp_w < 32'sd32767 |=> freq_ref_o == 16'($past(sp_w)) && !active_o)
    else $error("cancel did not pass setpoint");
  a_mode_off: assert property (st.tick && run_i && cfg.mode == PPR_OFF |=> !active_o)
    else $error("regulator active in mode off");
  a_neg_clamp: assert property (st.tick && run_i && !cfg.negh |=> !reverse_o)
    else $error("reversal with zero limit selected");
  a_rev_block: assert property (st.tick && cfg.rev_prohibit |=> !reverse_o)
    else $error("reversal while prohibited");
  a_tick_gap: assert property (st.tick |=> !st.tick [*8])
    else $error("control period too short");
  a_lag_zero: assert property (st.tick && run_i && en_w && !canc_w && cfg.lag == 14'h0000
    |=> st.lag == ($past(x_w) <<< `PPR_FRAC))
    else $error("zero lag did not pass value");
  a_gain_zero: assert property (st.tick && run_i && cfg.fgain == 8'h00 |=> st.mon == 0)
    else $error("zero output gain left output");
  a_out_limit: assert property (st.tick && run_i && en_w && !canc_w && cfg.mode == PPR_PID_DEV
    && cfg.bias == 11'h000 && cfg.lag == 14'h0000 && cfg.fgain == 8'h0a
    |=> 32'(freq_ref_o) <= $past(olim_w))
    else $error("combined result above limit");

  c_cancel: cover property (st.tick && run_i && canc_w);
  c_reverse: cover property (reverse_o && active_o);
  c_integ_sat: cover property (run_i && st.integ == ilim_w && ilim_w != 0);
  c_add_mode: cover property (active_o && cfg.mode == PPR_ADD_FF);
endmodule // ppr_top
`default_nettype wire

// file: ppr_sensor_model.sv
// Sensor model: setpoint, feedback and step reference sources of the regulator.
// Assumes the bench sets targets on the core clock; codes use 16384 as full scale.
`timescale 1ns/1ps
`default_nettype none
module ppr_sensor_model (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Behaviour controls.
  input wire logic slow_i,
  input wire logic invert_i,
  // Targets from the bench.
  input wire logic signed [15:0] sp_i,
  input wire logic signed [15:0] fb_i,
  input wire logic signed [15:0] step_i,
  // Converter codes towards the regulator.
  output logic signed [15:0] analog1_o,
  output logic signed [15:0] analog2_o,
  output logic signed [15:0] step_ref_o
);
  logic signed [15:0] fb_tgt;
  // A slow sensor slews by at most 512 codes a cycle, as a filtered input would.
  function automatic logic signed [15:0] mv(input logic signed [15:0] cur,
                                            input logic signed [15:0] tgt, input logic slw);
    logic signed [16:0] df;
    df = 17'(tgt) - 17'(cur);
    if (!slw || (df <= 17'sh00200 && df >= -17'sh00200)) return tgt;
    return (df > 0) ? cur + 16'sh0200 : cur - 16'sh0200;
  endfunction
  // Inverse feedback comes from flipping the input's gain and bias, not from a mode.
  assign fb_tgt = invert_i ? 16'sh4000 - fb_i : fb_i;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      analog1_o <= 16'sh0000;
      analog2_o <= 16'sh0000;
      step_ref_o <= 16'sh0000;
    end else begin
      analog1_o <= mv(analog1_o, sp_i, slow_i);
      analog2_o <= mv(analog2_o, fb_tgt, slow_i);
      step_ref_o <= mv(step_ref_o, step_i, slow_i);
    end
  end
endmodule // ppr_sensor_model
`default_nettype wire

// file: tb_top.sv
// Self-checking bench for the process regulator with a sensor model at its inputs.
// Assumes outputs settle within a few control periods of CC cycles.
`timescale 1ns/1ps
`default_nettype none
`include "ppr_cfg.svh"
module tb_top;
  localparam int CC = 20;
  localparam logic [7:0] A_KP = 8'h04, A_TI = 8'h08, A_ILIM = 8'h0c, A_TD = 8'h10;
  localparam logic [7:0] A_OLIM = 8'h14, A_BIAS = 8'h18, A_LAG = 8'h1c, A_SENSE = 8'h20;
  localparam logic [7:0] A_FGAIN = 8'h24, A_NEGH = 8'h28, A_MISC = 8'h2c;
  localparam logic [7:0] BA [10] = '{A_KP, A_TI, A_ILIM, A_TD, A_OLIM, A_BIAS, A_LAG, A_SENSE,
                                     A_FGAIN, A_NEGH};
  localparam logic [31:0] BD [10] = '{32'h64, 32'h0, 32'h3e8, 32'h0, 32'h3e8, 32'h0, 32'h0,
                                      32'h0, 32'ha, 32'h0};
  localparam logic [31:0] RD [10] = '{32'h64, 32'h64, 32'h3e8, 32'h0, 32'h3e8, 32'h0, 32'h0,
                                      32'h0, 32'ha, 32'h0};
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] awaddr_i = 8'h00;
  logic [7:0] araddr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0;
  logic [3:0] wstrb_i = 4'h0;
  logic awvalid_i = 1'b0, wvalid_i = 1'b0, bready_i = 1'b0, arvalid_i = 1'b0, rready_i = 1'b0;
  logic run_i = 1'b0, cancel_contact_i = 1'b0, slow = 1'b0, inv = 1'b0;
  logic signed [15:0] sp = 16'sh07d0, fb = 16'sh1770, step = 16'sh0bb8;
  logic awready_o, wready_o, bvalid_o, arready_o, rvalid_o, reverse_o, active_o;
  logic [1:0] bresp_o, rresp_o;
  logic [31:0] rdata_o;
  logic signed [15:0] analog1_i, analog2_i, step_ref_i, freq_ref_o;
  int bad_count = 0;
  int n_tests = 0;

  ppr_sensor_model SENS (.clk_i(core_clk_i), .rst_i(rst_i), .slow_i(slow), .invert_i(inv),
    .sp_i(sp), .fb_i(fb), .step_i(step), .analog1_o(analog1_i), .analog2_o(analog2_i),
    .step_ref_o(step_ref_i));
  ppr_top #(.CTRL_CYCLES(CC)) DUT (.core_clk_i, .rst_i, .awaddr_i, .awvalid_i, .awready_o,
    .wdata_i, .wstrb_i, .wvalid_i, .wready_o, .bresp_o, .bvalid_o, .bready_i, .araddr_i,
    .arvalid_i, .arready_o, .rdata_o, .rresp_o, .rvalid_o, .rready_i, .run_i,
    .cancel_contact_i, .analog1_i, .analog2_i, .step_ref_i, .freq_ref_o, .reverse_o, .active_o);

  always #10 core_clk_i = ~core_clk_i;

  task automatic final_report();
    $display("Checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic fq(input logic [15:0] e);
    chk("freq_ref", {16'h0000, e}, {16'h0000, freq_ref_o});
  endtask
  task automatic bit_chk(input string nm, input logic e, input logic g);
    chk(nm, {31'h0, e}, {31'h0, g});
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge core_clk_i);
    awaddr_i <= a;
    wdata_i <= d;
    wstrb_i <= 4'hf;
    awvalid_i <= 1'b1;
    wvalid_i <= 1'b1;
    bready_i <= 1'b1;
    while (1) begin
      @(posedge core_clk_i);
      if (awvalid_i && awready_o) awvalid_i <= 1'b0;
      if (wvalid_i && wready_o) wvalid_i <= 1'b0;
      if (bvalid_o) begin
        r = bresp_o;
        bready_i <= 1'b0;
        break;
      end
    end
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge core_clk_i);
    araddr_i <= a;
    arvalid_i <= 1'b1;
    rready_i <= 1'b1;
    while (1) begin
      @(posedge core_clk_i);
      if (arvalid_i && arready_o) arvalid_i <= 1'b0;
      if (rvalid_o) begin
        d = rdata_o;
        r = rresp_o;
        rready_i <= 1'b0;
        break;
      end
    end
  endtask
  task automatic wok(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    wr(a, d, r);
    chk("bresp", 32'h0, {30'h0, r});
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk("rdata", e, d);
  endtask
  function automatic logic [31:0] misc(input logic rf, input logic rp, input logic [1:0] s2);
    return {9'h0, `PPR_FN_CANCEL, 3'h0, `PPR_FN_PID_FB, 4'h0, s2, rp, rf};
  endfunction
  task automatic settle();
    repeat (3 * CC + 4) @(posedge core_clk_i);
  endtask
  task automatic go();
    @(posedge core_clk_i);
    run_i <= 1'b1;
    settle();
  endtask
  task automatic wt();
    for (int i = 0; i < 2 * CC + 8; i++) begin
      @(posedge core_clk_i);
      if (freq_ref_o !== 16'h0000) break;
    end
  endtask
  // Stops the drive, then loads a plain proportional setup: setpoint 2000, feedback 6000.
  task automatic base(input logic [2:0] m);
    @(posedge core_clk_i);
    run_i <= 1'b0;
    cancel_contact_i <= 1'b0;
    sp <= 16'sh07d0;
    fb <= 16'sh1770;
    wok(`PPR_OFF_MODE, {29'h0, m});
    foreach (BA[i]) wok(BA[i], BD[i]);
    wok(A_MISC, misc(1'b1, 1'b0, 2'h0));
  endtask

  task automatic t_reset();
    logic [31:0] d;
    logic [1:0] r;
    fq(16'h0000);
    rchk(`PPR_OFF_MODE, 32'h0);
    foreach (BA[i]) rchk(BA[i], RD[i]);
    rd(8'h40, d, r);
    chk("rresp_unmapped", 32'h2, {30'h0, r});
    chk("rdata_unmapped", 32'h0, d);
    wr(8'h40, 32'hffff_ffff, r);
    chk("bresp_unmapped", 32'h2, {30'h0, r});
  endtask
  task automatic t_modes();
    logic [15:0] ex [8] = '{16'h07d0, 16'h0fa0, 16'h0fa0, 16'h1770, 16'h1770, 16'h07d0,
                            16'h07d0, 16'h07d0};
    for (int m = 0; m < 8; m++) begin
      base(3'(m));
      go();
      fq(ex[m]);
      bit_chk("active", m inside {[1:4]}, active_o);
    end
  endtask
  task automatic t_source();
    base(3'h0);
    slow <= 1'b1;
    wok(A_MISC, misc(1'b0, 1'b0, 2'h0));
    go();
    fq(16'h0bb8);
    wok(A_MISC, misc(1'b1, 1'b0, 2'h0));
    settle();
    fq(16'h07d0);
    @(posedge core_clk_i);
    run_i <= 1'b0;
    slow <= 1'b0;
    repeat (3) @(posedge core_clk_i);
    fq(16'h0000);
  endtask
  task automatic t_sense();
    base(3'h1);
    wok(A_SENSE, 32'h1);
    go();
    fq(16'h0000);
    bit_chk("reverse", 1'b0, reverse_o);
    rchk(`PPR_OFF_MON, 32'hffff_f060);
    wok(A_NEGH, 32'h1);
    settle();
    fq(16'h0fa0);
    bit_chk("reverse", 1'b1, reverse_o);
    wok(A_MISC, misc(1'b1, 1'b1, 2'h0));
    settle();
    bit_chk("reverse", 1'b0, reverse_o);
  endtask
  task automatic t_gain();
    base(3'h1);
    wok(A_KP, 32'hfa);
    go();
    fq(16'h2710);
    wok(A_OLIM, 32'hfa);
    settle();
    fq(16'h1000);
    wok(A_OLIM, 32'h3e8);
    wok(A_KP, 32'h64);
    wok(A_BIAS, 32'h7d);
    settle();
    fq(16'h17a0);
    wok(A_BIAS, 32'h0);
    wok(A_FGAIN, 32'h14);
    settle();
    fq(16'h1f40);
    rchk(`PPR_OFF_MON, 32'h1f40);
  endtask
  task automatic t_fb();
    base(3'h1);
    wok(A_MISC, misc(1'b1, 1'b0, 2'h2));
    fb <= 16'sh1f8d;
    go();
    fq(16'h0fa0);
    wok(A_MISC, misc(1'b1, 1'b0, 2'h1));
    fb <= 16'sh2890;
    inv <= 1'b1;
    settle();
    fq(16'h0fa0);
    inv <= 1'b0;
  endtask
  task automatic t_cancel();
    base(3'h1);
    cancel_contact_i <= 1'b1;
    go();
    fq(16'h07d0);
    bit_chk("active", 1'b0, active_o);
    rchk(`PPR_OFF_STAT, 32'h4);
    @(posedge core_clk_i);
    cancel_contact_i <= 1'b0;
    settle();
    fq(16'h0fa0);
    rchk(`PPR_OFF_STAT, 32'h1);
  endtask
  task automatic t_integ();
    base(3'h1);
    wok(A_KP, 32'h0);
    wok(A_TI, 32'h1);
    wok(A_ILIM, 32'h7d);
    @(posedge core_clk_i);
    run_i <= 1'b1;
    wt();
    fq(16'h0190);
    repeat (30 * CC) @(posedge core_clk_i);
    fq(16'h0800);
    @(posedge core_clk_i);
    run_i <= 1'b0;
    fb <= 16'sh07d0;
    repeat (3) @(posedge core_clk_i);
    fq(16'h0000);
    go();
    fq(16'h0000);
  endtask
  task automatic t_deriv();
    base(3'h1);
    wok(A_KP, 32'h0);
    wok(A_TD, 32'h64);
    fb <= 16'sh07d0;
    go();
    fq(16'h0000);
    @(posedge core_clk_i);
    fb <= 16'sh0960;
    wt();
    bit_chk("deriv_kick", 1'b1, freq_ref_o >= 16'h1f40);
    repeat (CC + 2) @(posedge core_clk_i);
    fq(16'h0000);
    wok(A_LAG, 32'h64);
    @(posedge core_clk_i);
    run_i <= 1'b0;
    wok(A_TD, 32'h0);
    wok(A_KP, 32'h64);
    go();
    bit_chk("lag_slow", 1'b1, freq_ref_o < 16'h0064);
    wok(A_LAG, 32'h0);
    settle();
    fq(16'h0190);
    // Mode 2 differentiates feedback only, so a setpoint step gives no kick.
    base(3'h2);
    wok(A_KP, 32'h0);
    wok(A_TD, 32'h64);
    go();
    @(posedge core_clk_i);
    sp <= 16'sh03e8;
    wt();
    fq(16'h0000);
  endtask

  initial begin
    repeat (2) @(posedge core_clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_modes();
    t_source();
    t_sense();
    t_gain();
    t_fb();
    t_cancel();
    t_integ();
    t_deriv();
    final_report();
  end
  initial begin
    repeat (40000) @(posedge core_clk_i);
    bad_count++;
    $display("Error watchdog expected finish seen timeout");
    final_report();
  end
endmodule // tb_top
`default_nettype wire
